// file: pkg/mailbox_pkg.sv
// constants shared by the host command mailbox and its status register
// assumes one 25 MHz clock and an 8-bit register port behind the serial slave
`default_nettype none
package mailbox_pkg;
  // register offsets
  localparam logic [7:0] IRQ_ENABLE_ADDR      = 8'h03;
  localparam logic [7:0] PARAM_MBOX_ADDR      = 8'h17;
  localparam logic [7:0] CMD_MBOX_ADDR        = 8'h18;
  localparam logic [7:0] CMD_RESPONSE_ADDR    = 8'h20;
  localparam logic [7:0] IRQ_STATUS_ADDR      = 8'h21;
  localparam logic [7:0] VIS_RESULT_LOW_ADDR  = 8'h22;
  // reset values
  localparam logic [7:0] REG_RESET_VALUE      = 8'h00;
  // interrupt status layout
  localparam int unsigned CMD_DONE_BIT        = 5;
  localparam int unsigned PROX_THREE_BIT      = 4;
  localparam int unsigned PROX_TWO_BIT        = 3;
  localparam int unsigned PROX_ONE_BIT        = 2;
  localparam int unsigned LIGHT_FIELD_LSB     = 0;
  localparam int unsigned LIGHT_FIELD_W       = 2;
  localparam int unsigned LIGHT_ENABLE_BIT    = 0;
  localparam int unsigned STATUS_USED_BITS    = 6;
  // command codes and error codes
  localparam logic [7:0] NO_OPERATION_COMMAND = 8'h00;
  localparam logic [7:0] RESET_COMMAND        = 8'h01;
  localparam int unsigned ERROR_MARK_BIT      = 7;
  localparam logic [7:0] ERR_VIS_OVERFLOW     = 8'h8C;
  localparam logic [7:0] ERR_IR_OVERFLOW      = 8'h8D;
  localparam logic [7:0] ERR_AUX_OVERFLOW     = 8'h8E;
  // sequencer handshake states, gray along standby -> busy -> ready
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_BUSY    = 2'b01,
    ST_READY   = 2'b11
  } mbox_state_t;
endpackage
`default_nettype wire

// file: hdl/irq_status_bank.sv
// sticky interrupt status bits: hardware sets, host clears by writing ones
// assumes set and clear strobes come from logic on the same clock
`default_nettype none
module irq_status_bank
  import mailbox_pkg::*;
#(
  parameter int unsigned WIDTH = 8
)(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // per-bit controls
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clear_in,
  // state
  output logic      [WIDTH-1:0] status_out
);
  if (WIDTH < STATUS_USED_BITS)
  begin : g_width_check
    $error("irq_status_bank: WIDTH too small for the status layout");
  end

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } bank_state_t;

  bank_state_t state_q;
  bank_state_t state_d;

  always_comb
  begin
    state_d = state_q;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (clear_in[i])
      begin
        state_d.flags[i] = 1'b0;
      end
      // a set in the same cycle as a clear wins, so no event is lost
      if (set_in[i])
      begin
        state_d.flags[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign status_out = state_q.flags;
endmodule
`default_nettype wire

// file: hdl/sensor_host_command_mailbox.sv
// host command mailbox, response register, interrupt status and result byte
// assumes a serial slave front end turning bus transfers into register strobes
`default_nettype none
module sensor_host_command_mailbox
  import mailbox_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // register port from the serial slave
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // sequencer command handshake
  output logic            seq_cmd_valid_out,
  output logic      [7:0] seq_cmd_code_out,
  output logic      [7:0] seq_param_out,
  input  wire logic       seq_cmd_done_in,
  input  wire logic       seq_sleep_in,
  // sequencer errors
  input  wire logic       seq_error_in,
  input  wire logic [7:0] seq_error_code_in,
  input  wire logic       vis_overflow_in,
  input  wire logic       ir_overflow_in,
  input  wire logic       aux_overflow_in,
  // measurement events and results
  input  wire logic [2:0] prox_done_in,
  input  wire logic       light_done_in,
  input  wire logic [1:0] light_code_in,
  input  wire logic       vis_result_valid_in,
  input  wire logic [7:0] vis_result_low_in,
  // device pins and state
  output logic            int_n_out,
  output logic            awake_out
);
  typedef struct packed {
    mbox_state_t fsm;
    logic [7:0]  param_mbox;
    logic [7:0]  command;
    logic [7:0]  response;
    logic [7:0]  irq_enable;
    logic [7:0]  vis_result;
    logic [7:0]  rdata;
    logic        cmd_valid;
    logic        int_n;
    logic        awake;
  } mbox_reg_t;

  mbox_reg_t  state_q;
  mbox_reg_t  state_d;
  logic [7:0] status_set;
  logic [7:0] status_clear;
  logic [7:0] status;
  logic [7:0] status_enable;

  irq_status_bank #(
    .WIDTH (8)
  ) u_status (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .set_in     (status_set),
    .clear_in   (status_clear),
    .status_out (status)
  );

  always_comb
  begin
    state_d      = state_q;
    status_set   = '0;
    status_clear = '0;
    state_d.cmd_valid = 1'b0;

    if (reg_wr_in && reg_addr_in == PARAM_MBOX_ADDR)
    begin
      state_d.param_mbox = reg_wdata_in;
    end
    if (reg_wr_in && reg_addr_in == IRQ_ENABLE_ADDR)
    begin
      state_d.irq_enable = reg_wdata_in;
    end
    if (reg_wr_in && reg_addr_in == CMD_RESPONSE_ADDR)
    begin
      state_d.response = reg_wdata_in;
    end
    // result byte is overwritten by each new measurement
    if (reg_wr_in && reg_addr_in == VIS_RESULT_LOW_ADDR)
    begin
      state_d.vis_result = reg_wdata_in;
    end
    if (vis_result_valid_in)
    begin
      state_d.vis_result = vis_result_low_in;
    end
    if (reg_wr_in && reg_addr_in == IRQ_STATUS_ADDR)
    begin
      status_clear = reg_wdata_in;
    end

    unique case (state_q.fsm)
      ST_STANDBY, ST_READY:
      begin
        if (reg_wr_in && reg_addr_in == CMD_MBOX_ADDR)
        begin
          state_d.command = reg_wdata_in;
          // held error blocks all but reset and no-operation
          if (!state_q.response[ERROR_MARK_BIT]
              || reg_wdata_in == RESET_COMMAND
              || reg_wdata_in == NO_OPERATION_COMMAND)
          begin
            state_d.cmd_valid = 1'b1;
            state_d.fsm       = ST_BUSY;
            // error released by reset or no-operation
            if (reg_wdata_in == RESET_COMMAND || reg_wdata_in == NO_OPERATION_COMMAND)
            begin
              state_d.response = REG_RESET_VALUE;
            end
          end
          else
          begin
            state_d.fsm = ST_READY;
          end
        end
        else if (seq_sleep_in && state_q.fsm == ST_READY)
        begin
          state_d.fsm = ST_STANDBY;
        end
      end
      ST_BUSY:
      begin
        if (seq_cmd_done_in)
        begin
          state_d.fsm = ST_READY;
          status_set[CMD_DONE_BIT] = 1'b1;
        end
      end
    endcase
    // awake flag kept in a flop so the output needs no decode after the register
    state_d.awake = (state_d.fsm != ST_STANDBY);

    // error codes carry the top bit; errors win over a host write
    if (seq_error_in)
    begin
      state_d.response                 = seq_error_code_in;
      state_d.response[ERROR_MARK_BIT] = 1'b1;
    end
    if (aux_overflow_in)
    begin
      state_d.response = ERR_AUX_OVERFLOW;
    end
    if (ir_overflow_in)
    begin
      state_d.response = ERR_IR_OVERFLOW;
    end
    if (vis_overflow_in)
    begin
      state_d.response = ERR_VIS_OVERFLOW;
    end

    status_set[PROX_ONE_BIT]   = prox_done_in[0];
    status_set[PROX_TWO_BIT]   = prox_done_in[1];
    status_set[PROX_THREE_BIT] = prox_done_in[2];
    status_set[LIGHT_FIELD_LSB +: LIGHT_FIELD_W] = light_done_in ? light_code_in : 2'b00;

    // per-channel enables for the proximity bits; light field shares one enable; command done has none and never drives the pin
    status_enable = '0;
    status_enable[PROX_ONE_BIT]   = state_q.irq_enable[PROX_ONE_BIT];
    status_enable[PROX_TWO_BIT]   = state_q.irq_enable[PROX_TWO_BIT];
    status_enable[PROX_THREE_BIT] = state_q.irq_enable[PROX_THREE_BIT];
    status_enable[LIGHT_FIELD_LSB +: LIGHT_FIELD_W] = {LIGHT_FIELD_W{
      state_q.irq_enable[LIGHT_ENABLE_BIT]}};
    state_d.int_n = ~|(status & status_enable);

    // reads answer one cycle later; unmapped addresses read zero
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        IRQ_ENABLE_ADDR:     state_d.rdata = state_q.irq_enable;
        PARAM_MBOX_ADDR:     state_d.rdata = state_q.param_mbox;
        CMD_MBOX_ADDR:       state_d.rdata = state_q.command;
        CMD_RESPONSE_ADDR:   state_d.rdata = state_q.response;
        IRQ_STATUS_ADDR:     state_d.rdata = status & 8'h3F;
        VIS_RESULT_LOW_ADDR: state_d.rdata = state_q.vis_result;
        default:             state_d.rdata = REG_RESET_VALUE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q            <= '0;
      state_q.fsm        <= ST_STANDBY;
      state_q.int_n      <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign reg_rdata_out     = state_q.rdata;
  assign seq_cmd_valid_out = state_q.cmd_valid;
  assign seq_cmd_code_out  = state_q.command;
  assign seq_param_out     = state_q.param_mbox;
  assign int_n_out         = state_q.int_n;
  assign awake_out         = state_q.awake;
endmodule
`default_nettype wire

// file: dv/mailbox_props.sv
// checker: timing relations on the mailbox top ports
// assumes one clock domain and the bind at the foot of this file
`default_nettype none
module mailbox_props
  import mailbox_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       seq_cmd_valid_out,
  input wire logic [7:0] seq_cmd_code_out,
  input wire logic [7:0] seq_param_out,
  input wire logic       vis_overflow_in,
  input wire logic [2:0] prox_done_in,
  input wire logic       light_done_in,
  input wire logic       int_n_out,
  input wire logic       awake_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic cmd_wr;
  logic quiet;
  logic prm_wr;
  logic sts_rd;
  logic rsp_rd;
  logic sts_clr;
  logic rdata_vis;
  assign cmd_wr    = reg_wr_in && reg_addr_in == CMD_MBOX_ADDR;
  assign quiet     = prox_done_in == 3'h0 && !light_done_in;
  assign prm_wr    = reg_wr_in && reg_addr_in == PARAM_MBOX_ADDR;
  assign sts_rd    = reg_rd_in && reg_addr_in == IRQ_STATUS_ADDR;
  assign rsp_rd    = reg_rd_in && reg_addr_in == CMD_RESPONSE_ADDR;
  assign sts_clr   = reg_wr_in && reg_addr_in == IRQ_STATUS_ADDR && &reg_wdata_in[5:0];
  assign rdata_vis = reg_rdata_out == ERR_VIS_OVERFLOW;
  a_cmd_issue: assert property (seq_cmd_valid_out |-> $past(cmd_wr))
    else $error("command issued without a write");
  a_cmd_code: assert property (seq_cmd_valid_out |-> seq_cmd_code_out == $past(reg_wdata_in))
    else $error("command code differs from written byte");
  a_cmd_pulse: assert property (seq_cmd_valid_out |=> !seq_cmd_valid_out)
    else $error("command strobe longer than one cycle");
  a_param_level: assert property (prm_wr |=> seq_param_out == $past(reg_wdata_in))
    else $error("parameter byte not passed on");
  a_standby_held: assert property (!awake_out && !cmd_wr |=> !awake_out)
    else $error("woke without a command write");
  a_status_mask: assert property (sts_rd |=> reg_rdata_out[7:6] == 2'b00)
    else $error("reserved status bits read nonzero");
  a_vis_code: assert property (vis_overflow_in ##2 rsp_rd |=> rdata_vis)
    else $error("wrong visible overflow code");
  a_clear_release: assert property ((sts_clr && quiet) ##1 quiet |=> int_n_out)
    else $error("pin still low after clearing all flags");
  c_cmd: cover property (seq_cmd_valid_out);
  c_pin: cover property ($fell(int_n_out));
  c_vis: cover property (vis_overflow_in);
endmodule
bind sensor_host_command_mailbox mailbox_props mailbox_props_inst (.clk_in, .rst_n_in,
  .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .seq_cmd_valid_out,
  .seq_cmd_code_out, .seq_param_out, .vis_overflow_in, .prox_done_in, .light_done_in,
  .int_n_out, .awake_out);
`default_nettype wire

// file: dv/seq_model.sv
// sequencer stand-in: finishes each command, then drops back to standby
// assumes one-cycle command strobes from the mailbox
`default_nettype none
module seq_model #(
  parameter int unsigned DONE_LAT = 4
)(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic cmd_valid_in,
  output logic      done_out,
  output logic      sleep_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt;
  // done after a fixed run time
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      cnt       <= 0;
      done_out  <= 1'b0;
      sleep_out <= 1'b0;
    end
    else
    begin
      cnt       <= cmd_valid_in ? DONE_LAT : (cnt != 0 ? cnt - 1 : 0);
      done_out  <= cnt == 1;
      sleep_out <= done_out;
    end
endmodule
`default_nettype wire

// file: dv/tb.sv
// bench: register port tasks and directed sequences for the mailbox
// assumes the sequencer stand-in on the command side
`default_nettype none
module tb;
  import mailbox_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_in = 0, rst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
  logic [8:0] ev = 9'h000;
  logic [7:0] reg_rdata_out, seq_cmd_code_out, seq_param_out;
  logic       seq_cmd_valid_out, done, sleep, int_n_out, awake_out;
  int         err_total = 0, checked = 0, cmds = 0, cyc = 0, tno = 0;
  sensor_host_command_mailbox sensor_host_command_mailbox_inst (.clk_in, .rst_n_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .seq_cmd_valid_out,
    .seq_cmd_code_out, .seq_param_out, .seq_cmd_done_in(done), .seq_sleep_in(sleep),
    .seq_error_in(ev[3]), .seq_error_code_in(8'h12), .vis_overflow_in(ev[0]),
    .ir_overflow_in(ev[1]), .aux_overflow_in(ev[2]), .prox_done_in(ev[6:4]),
    .light_done_in(ev[7]), .light_code_in(2'b10), .vis_result_valid_in(ev[8]),
    .vis_result_low_in(8'h3C), .int_n_out, .awake_out);
  seq_model seq_model_inst (.clk_in, .rst_n_in, .cmd_valid_in(seq_cmd_valid_out),
    .done_out(done), .sleep_out(sleep));
  initial
    forever #20 clk_in = ~clk_in;
  task automatic end_sim;
    $display("compares %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, exp);
  endtask
  task automatic pulse(input logic [8:0] m);
    @(posedge clk_in);
    ev <= m;
    @(posedge clk_in);
    ev <= 9'h000;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic tdone;
    $display("test %0d done", tno);
    tno++;
  endtask
  // a hang would otherwise never reach the verdict
  always @(posedge clk_in)
  begin
    cyc++;
    if (seq_cmd_valid_out === 1'b1)
      cmds++;
    if (cyc == 3000)
    begin
      $display("[FAIL] %0t timeout", $time);
      err_total++;
      end_sim();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    wr(8'h07, 8'h17);
    rd(IRQ_STATUS_ADDR, REG_RESET_VALUE);
    rd(PARAM_MBOX_ADDR, REG_RESET_VALUE);
    wr(PARAM_MBOX_ADDR, 8'h5A);
    rd(PARAM_MBOX_ADDR, 8'h5A);
    chk(seq_param_out, 8'h5A);
    chk({7'h00, awake_out}, 8'h00);
    tdone();
    wr(CMD_MBOX_ADDR, 8'h05);
    #1 chk({7'h00, awake_out}, 8'h01);
    wt(10);
    chk(seq_cmd_code_out, 8'h05);
    chk(cmds[7:0], 8'h01);
    chk({7'h00, awake_out}, 8'h00);
    rd(IRQ_STATUS_ADDR, 8'h20);
    chk({7'h00, int_n_out}, 8'h01);
    wr(IRQ_STATUS_ADDR, 8'h20);
    rd(IRQ_STATUS_ADDR, 8'h00);
    tdone();
    wr(IRQ_ENABLE_ADDR, 8'h04);
    pulse(9'h020);
    wt(2);
    chk({7'h00, int_n_out}, 8'h01);
    pulse(9'h010);
    wt(2);
    chk({7'h00, int_n_out}, 8'h00);
    rd(IRQ_STATUS_ADDR, 8'h0C);
    wr(IRQ_STATUS_ADDR, 8'h08);
    rd(IRQ_STATUS_ADDR, 8'h04);
    wr(IRQ_ENABLE_ADDR, 8'h01);
    wt(1);
    chk({7'h00, int_n_out}, 8'h01);
    pulse(9'h080);
    wt(2);
    chk({7'h00, int_n_out}, 8'h00);
    rd(IRQ_STATUS_ADDR, 8'h06);
    wr(IRQ_STATUS_ADDR, 8'hFF);
    wt(2);
    chk({7'h00, int_n_out}, 8'h01);
    rd(IRQ_STATUS_ADDR, 8'h00);
    chk({7'h00, awake_out}, 8'h00);
    tdone();
    for (int k = 0; k < 3; k++)
    begin
      pulse(9'h001 << k);
      rd(CMD_RESPONSE_ADDR, ERR_VIS_OVERFLOW + 8'(k));
      wr(CMD_MBOX_ADDR, 8'h05);
      wt(6);
      rd(CMD_RESPONSE_ADDR, ERR_VIS_OVERFLOW + 8'(k));
      wr(CMD_MBOX_ADDR, k[0] ? RESET_COMMAND : NO_OPERATION_COMMAND);
      wt(8);
      rd(CMD_RESPONSE_ADDR, 8'h00);
    end
    chk(cmds[7:0], 8'h04);
    pulse(9'h008);
    rd(CMD_RESPONSE_ADDR, 8'h92);
    tdone();
    pulse(9'h100);
    rd(VIS_RESULT_LOW_ADDR, 8'h3C);
    rd(8'h40, 8'h00);
    tdone();
    // mid-run reset from an awake, interrupting state
    pulse(9'h080);
    wr(CMD_MBOX_ADDR, 8'h05);
    #1 chk({7'h00, awake_out}, 8'h01);
    chk({7'h00, int_n_out}, 8'h00);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    wt(2);
    chk({7'h00, awake_out}, 8'h00);
    chk({7'h00, int_n_out}, 8'h01);
    chk(seq_param_out, REG_RESET_VALUE);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(IRQ_STATUS_ADDR, REG_RESET_VALUE);
    rd(CMD_RESPONSE_ADDR, REG_RESET_VALUE);
    chk(cmds[7:0], 8'h04);
    tdone();
    end_sim();
  end
endmodule
`default_nettype wire
